// ---- core/vds_pkg.sv ----
// Package with constants for the vector drive start/stop block.
package vds_pkg;
   // ==========================================================================
   // Register map, word offsets on the Avalon-MM slave.
   localparam logic [2:0] ADDR_OUT_CTRL  = 3'h0;
   localparam logic [2:0] ADDR_POLARITY  = 3'h1;
   localparam logic [2:0] ADDR_BYTE_PORT = 3'h2;
   localparam logic [2:0] ADDR_STROBE    = 3'h3;
   localparam logic [2:0] ADDR_STATUS    = 3'h4;
   localparam logic [2:0] ADDR_LANE      = 3'h5;
   localparam logic [2:0] ADDR_CONTROL   = 3'h6;
   // ==========================================================================
   // Output control register fields.
   localparam int OC_LOAD_N_BIT  = 7;
   localparam int OC_HS_POL_BIT  = 5;
   localparam int OC_JOINT_BIT   = 4;
   localparam logic [7:0] OC_RESET = 8'h80;
   // ==========================================================================
   // Polarity register fields.
   localparam int PR_CLK_EDGE_BIT    = 7;
   localparam int PR_GATE_LEVEL_BIT  = 6;
   localparam int PR_HALT_EDGE_BIT   = 5;
   localparam int PR_LAUNCH_EDGE_BIT = 4;
   localparam int PR_GATE_BYPASS_BIT = 3;
   localparam int PR_NO_FORCE_BIT    = 2;
   localparam int PR_HALT_OFF_BIT    = 1;
   localparam int PR_ARM_BIT         = 0;
   localparam logic [7:0] PR_RESET   = 8'h06;
   // ==========================================================================
   // Control register fields (input-section arm decode).
   localparam int CT_ARM_DECODE_BIT = 0;
   // ==========================================================================
   // Chip counter.
   localparam logic [3:0] CHIP_START = 4'h5;
   localparam logic [3:0] CHIP_LAST  = 4'hF;
   // ==========================================================================
   // Clock select codes.
   localparam logic [2:0] SEL_OSC    = 3'h3;
   localparam logic [2:0] SEL_PROBE  = 3'h4;
   localparam logic [2:0] SEL_STROBE = 3'h5;
   localparam logic [2:0] SEL_EXT    = 3'h6;
   localparam logic [2:0] SEL_STEP   = 3'h7;
   // ==========================================================================
   // Status nybble bits and module type code.
   localparam int ST_DRIVING_BIT = 3;
   localparam int ST_HS_RUN_BIT  = 2;
   // Module type code; the value is arbitrary.
   localparam logic [1:0] MODULE_TYPE = 2'h2;
endpackage

// ---- core/vds_core.sv ----
// Start/stop sequencing core with chip counter and Avalon-MM registers.
`timescale 1ns/1ps
// Notes on behaviour
// - Load low plus byte read presets count 5.
// - Byte write stores data, advances lane.
// - Count 15 selects control memory, carry.
// - Carry steps address, reloads counter.
// - Bits 7..4 pick clock/gate/halt/launch polarity.
// - Bit 3 bypasses the gate input.
// - Bit 2 low forces launch.
// - Bit 1 low lets halt edge stop.
// - Bit 0 zero clears arm flag unless joint bit set.
// - Select codes 3,4,5,6,7 map sources.
// - Selected clock blocked once drive finished.
// - Probe sync inverted before selection.
// - Qualified rising edge gives one step.
// - Qualify needs registered launch.
// - No halt, not finished; finish clears launch.
// - Gate received needed, bypass or level.
// - Arm low holds handshake run set.
// - Wait request rise clears handshake run.
// - Wait input edge sets handshake run.
// - Status bit 3 driving, bit 2 run.
// - Final vector flag finishes drive.
// - Loop stop latches last pass, finishes.
// - Arm set by bit 0 or joint decode.
module vds_core
   import vds_pkg::*;
(
   input  wire logic       clock,
   input  wire logic       reset_n,
   input  wire logic [2:0] avs_address,
   input  wire logic       avs_read,
   input  wire logic       avs_write,
   input  wire logic [31:0] avs_writedata,
   output logic [31:0]     avs_readdata,
   output logic            avs_waitrequest,
   input  wire logic       ext_drive_clock,
   input  wire logic       probe_sync,
   input  wire logic       onboard_oscillator_clock,
   input  wire logic       ext_launch,
   input  wire logic       ext_halt,
   input  wire logic       ext_gate,
   input  wire logic       wait_in,
   input  wire logic       final_vector_flag,
   input  wire logic       wait_request,
   input  wire logic       loop_stop_bit,
   input  wire logic       last_pass,
   output logic [7:0]      mem_write_data,
   output logic [10:0]     lane_write,
   output logic            addr_step_clock,
   output logic            step_pulse,
   output logic            clock_qualify_n
);
   // ==========================================================================
   // Input synchronisers.
   localparam int NSYNC = 10;
   logic [NSYNC-1:0] raw_in;
   logic [NSYNC-1:0] sync1_q;
   logic [NSYNC-1:0] sync2_q;
   logic [NSYNC-1:0] sync2_d;
   logic [NSYNC-1:0] prev_q;
   logic [NSYNC-1:0] rise;
   logic [NSYNC-1:0] fall;
   assign raw_in = {last_pass, loop_stop_bit, wait_request, final_vector_flag, wait_in,
                    ext_gate, ext_halt, ext_launch, onboard_oscillator_clock, ext_drive_clock};
   always_comb begin
      sync2_d = sync1_q;
   end
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         sync1_q <= '0;
         sync2_q <= '0;
         prev_q  <= '0;
      end else begin
         sync1_q <= raw_in;
         sync2_q <= sync2_d;
         prev_q  <= sync2_q;
      end
   end
   genvar gi;
   generate
      for (gi = 0; gi < NSYNC; gi++) begin : g_edge
         assign rise[gi] = sync2_q[gi] & ~prev_q[gi];
         assign fall[gi] = ~sync2_q[gi] & prev_q[gi];
      end
   endgenerate
   logic probe_q;
   logic probe_s_q;
   logic probe_p_q;
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         probe_q   <= 1'b0;
         probe_s_q <= 1'b0;
         probe_p_q <= 1'b0;
      end else begin
         probe_q   <= probe_sync;
         probe_s_q <= probe_q;
         probe_p_q <= probe_s_q;
      end
   end
   // ==========================================================================
   // Register bus and chip counter.
   logic [7:0]  out_ctrl_q, out_ctrl_d;
   logic [7:0]  pol_q, pol_d;
   logic [7:0]  ctrl_q, ctrl_d;
   logic [3:0]  chip_q, chip_d;
   logic        arm_q, arm_d;
   logic        strobe_q, strobe_d;
   logic        carry_q, carry_d;
   logic [7:0]  wdata_q, wdata_d;
   logic [10:0] lane_q, lane_d;
   logic [31:0] rdata_q, rdata_d;
   logic        wait_q, wait_d;
   logic        finished_q;
   logic        hs_run_q;
   logic        acc;
   assign acc = (avs_read | avs_write) & wait_q;
   always_comb begin
      out_ctrl_d = out_ctrl_q;
      pol_d      = pol_q;
      ctrl_d     = ctrl_q;
      chip_d     = chip_q;
      arm_d      = arm_q;
      strobe_d   = 1'b0;
      carry_d    = 1'b0;
      wdata_d    = wdata_q;
      lane_d     = '0;
      rdata_d    = rdata_q;
      wait_d     = 1'b1;
      if (acc) begin
         wait_d  = 1'b0;
         rdata_d = '0;
      end
      if (acc && avs_write) begin
         case (avs_address)
            ADDR_OUT_CTRL: out_ctrl_d = avs_writedata[7:0];
            ADDR_POLARITY: begin
               pol_d = {avs_writedata[7:1], 1'b0};
               if (!out_ctrl_q[OC_JOINT_BIT]) begin
                  arm_d = avs_writedata[PR_ARM_BIT];
               end
            end
            ADDR_CONTROL: ctrl_d = avs_writedata[7:0];
            ADDR_STROBE: strobe_d = 1'b1;
            ADDR_BYTE_PORT: begin
               wdata_d = avs_writedata[7:0];
               lane_d  = 11'h001 << (chip_q - CHIP_START);
               if (chip_q == CHIP_LAST) begin
                  carry_d = 1'b1;
                  chip_d  = CHIP_START;
               end else begin
                  chip_d = chip_q + 4'h1;
               end
            end
            default: ;
         endcase
      end
      if (acc && avs_read) begin
         case (avs_address)
            ADDR_BYTE_PORT: begin
               if (!out_ctrl_q[OC_LOAD_N_BIT]) begin
                  chip_d = CHIP_START;
               end
            end
            ADDR_STATUS: rdata_d = {28'h0, ~finished_q, hs_run_q, MODULE_TYPE};
            ADDR_OUT_CTRL: rdata_d = {24'h0, out_ctrl_q};
            ADDR_LANE: rdata_d = {28'h0, chip_q};
            ADDR_CONTROL: rdata_d = {24'h0, ctrl_q};
            default: rdata_d = '0;
         endcase
      end
      if (out_ctrl_q[OC_JOINT_BIT] && ctrl_q[CT_ARM_DECODE_BIT]) begin
         arm_d = 1'b1;
      end
   end
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         out_ctrl_q <= OC_RESET;
         pol_q      <= PR_RESET;
         ctrl_q     <= '0;
         chip_q     <= CHIP_START;
         arm_q      <= 1'b0;
         strobe_q   <= 1'b0;
         carry_q    <= 1'b0;
         wdata_q    <= '0;
         lane_q     <= '0;
         rdata_q    <= '0;
         wait_q     <= 1'b1;
      end else begin
         out_ctrl_q <= out_ctrl_d;
         pol_q      <= pol_d;
         ctrl_q     <= ctrl_d;
         chip_q     <= chip_d;
         arm_q      <= arm_d;
         strobe_q   <= strobe_d;
         carry_q    <= carry_d;
         wdata_q    <= wdata_d;
         lane_q     <= lane_d;
         rdata_q    <= rdata_d;
         wait_q     <= wait_d;
      end
   end
   // ==========================================================================
   // Clock selection and start/stop qualification.
   logic [2:0] sel;
   logic       src_rise;
   logic       ext_clk_edge;
   logic       launch_edge;
   logic       halt_edge;
   logic       gate_received;
   logic       wait_edge;
   logic       launch_q, launch_d;
   logic       halt_q, halt_d;
   logic       hs_run_d;
   logic       lastp_q, lastp_d;
   logic       finished_d;
   logic       qual;
   logic       step_d;
   logic       step_q;
   assign sel = out_ctrl_q[2:0];
   assign ext_clk_edge = pol_q[PR_CLK_EDGE_BIT] ? fall[0] : rise[0];
   assign launch_edge  = pol_q[PR_LAUNCH_EDGE_BIT] ? fall[2] : rise[2];
   assign halt_edge    = pol_q[PR_HALT_EDGE_BIT] ? fall[3] : rise[3];
   assign gate_received = pol_q[PR_GATE_BYPASS_BIT] |
                          (sync2_q[4] == pol_q[PR_GATE_LEVEL_BIT]);
   assign wait_edge = out_ctrl_q[OC_HS_POL_BIT] ? fall[5] : rise[5];
   always_comb begin
      case (sel)
         SEL_OSC:    src_rise = rise[1];
         SEL_PROBE:  src_rise = ~probe_s_q & probe_p_q;
         SEL_STROBE: src_rise = strobe_q;
         SEL_EXT:    src_rise = ext_clk_edge;
         SEL_STEP:   src_rise = carry_q;
         default:    src_rise = 1'b0;
      endcase
   end
   assign qual = launch_q & ~halt_q & ~finished_q & gate_received & hs_run_q;
   always_comb begin
      launch_d   = launch_q;
      halt_d     = halt_q;
      hs_run_d   = hs_run_q;
      lastp_d    = lastp_q;
      finished_d = finished_q;
      if (!pol_q[PR_NO_FORCE_BIT]) begin
         launch_d = 1'b1;
      end else if (launch_edge) begin
         launch_d = 1'b1;
      end
      if (!pol_q[PR_HALT_OFF_BIT] && halt_edge) begin
         halt_d = 1'b1;
      end
      if (fall[8]) begin
         lastp_d = sync2_q[9];
      end
      if (sync2_q[6] || (rise[8] && lastp_q)) begin
         finished_d = 1'b1;
      end
      if (rise[7]) begin
         hs_run_d = 1'b0;
      end
      if (wait_edge) begin
         hs_run_d = 1'b1;
      end
      if (!arm_q) begin
         hs_run_d   = 1'b1;
         halt_d     = 1'b0;
         finished_d = 1'b0;
         launch_d   = 1'b0;
         lastp_d    = 1'b0;
      end
      if (finished_q) begin
         launch_d = 1'b0;
      end
      step_d = src_rise & qual & ~finished_q;
   end
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         launch_q   <= 1'b0;
         halt_q     <= 1'b0;
         hs_run_q   <= 1'b1;
         lastp_q    <= 1'b0;
         finished_q <= 1'b0;
         step_q     <= 1'b0;
      end else begin
         launch_q   <= launch_d;
         halt_q     <= halt_d;
         hs_run_q   <= hs_run_d;
         lastp_q    <= lastp_d;
         finished_q <= finished_d;
         step_q     <= step_d;
      end
   end
   // ==========================================================================
   // Outputs.
   logic qn_q;
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         qn_q <= 1'b1;
      end else begin
         qn_q <= ~qual;
      end
   end
   assign avs_readdata    = rdata_q;
   assign avs_waitrequest = wait_q;
   assign mem_write_data  = wdata_q;
   assign lane_write      = lane_q;
   assign addr_step_clock = carry_q;
   assign step_pulse      = step_q;
   assign clock_qualify_n = qn_q;
   // ==========================================================================
   // Assertions.
   wrap_carry_a: assert property (@(posedge clock) disable iff (!reset_n)
      (acc && avs_write && avs_address == ADDR_BYTE_PORT && chip_q == CHIP_LAST)
      |=> (addr_step_clock && chip_q == CHIP_START))
      else $error("Carry or reload missing at last lane.");
   lane_adv_a: assert property (@(posedge clock) disable iff (!reset_n)
      (acc && avs_write && avs_address == ADDR_BYTE_PORT && chip_q != CHIP_LAST)
      |=> chip_q == $past(chip_q) + 4'h1)
      else $error("Chip counter did not advance.");
   chip_preset_a: assert property (@(posedge clock) disable iff (!reset_n)
      (acc && avs_read && avs_address == ADDR_BYTE_PORT && !out_ctrl_q[OC_LOAD_N_BIT])
      |=> chip_q == CHIP_START)
      else $error("Chip counter preset failed.");
   step_qual_a: assert property (@(posedge clock) disable iff (!reset_n)
      step_pulse |-> $past(qual))
      else $error("Step without qualification.");
   step_one_a: assert property (@(posedge clock) disable iff (!reset_n)
      step_pulse |=> !step_pulse)
      else $error("Step pulse longer than one cycle.");
   finish_blk_a: assert property (@(posedge clock) disable iff (!reset_n)
      (finished_q && arm_q) |=> !step_pulse && !launch_q)
      else $error("Step after drive finished.");
   final_vec_a: assert property (@(posedge clock) disable iff (!reset_n)
      (sync2_q[6] && arm_q && arm_d) |=> finished_q)
      else $error("Final vector did not finish drive.");
   wait_clr_a: assert property (@(posedge clock) disable iff (!reset_n)
      (rise[7] && !wait_edge && arm_q && arm_d) |=> !hs_run_q ##1 clock_qualify_n)
      else $error("Wait request did not suspend.");
   arm_hold_a: assert property (@(posedge clock) disable iff (!reset_n)
      !arm_q |=> hs_run_q)
      else $error("Handshake run not held while disarmed.");
   bus_ack_a: assert property (@(posedge clock) disable iff (!reset_n)
      (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("Bus answer late.");
endmodule // vds_core

// ---- tb/vds_far_end.sv ----
// Model of the external clock sources that face the start/stop block.
`timescale 1ns/1ps
module vds_far_end (
   input  wire logic clock,
   output logic      ext_drive_clock,
   output logic      probe_sync,
   output logic      onboard_oscillator_clock
);
   logic [2:0] src_q = 3'h0;
   assign {ext_drive_clock, probe_sync, onboard_oscillator_clock} = src_q;
   // Gives n rises on one source and leaves it high; sources stand still between bursts.
   task automatic burst(input int idx, input int n);
      for (int i = 0; i < n; i++) begin
         if (i > 0) begin
            src_q[idx] <= 1'b0;
            repeat (6) @(posedge clock);
         end
         src_q[idx] <= 1'b1;
         repeat (6) @(posedge clock);
      end
   endtask
   task automatic park();
      @(posedge clock);
      src_q <= 3'h0;
   endtask
endmodule // vds_far_end

// ---- tb/tb_vds_core.sv ----
// Self-checking bench for the vector drive start/stop core.
`timescale 1ns/1ps
module tb_vds_core import vds_pkg::*; ();
   localparam logic [2:0] CSEL [4] = '{SEL_EXT, SEL_EXT, SEL_PROBE, SEL_OSC};
   localparam int         CIDX [4] = '{2, 2, 1, 0};
   localparam int         CFALL [4] = '{0, 1, 1, 0};
   logic        clock = 1'b0;
   logic        reset_n = 1'b0;
   logic [2:0]  addr = 3'h0;
   logic        rd = 1'b0, wr = 1'b0;
   logic [31:0] wdata = 32'h0, rdata;
   logic        waitreq, step_clk, step, qual_n, ext_clk, probe, osc;
   logic        launch = 1'b0, halt = 1'b0, gate = 1'b0, wait_in = 1'b0;
   logic        fin = 1'b0, wreq = 1'b0, loop_bit = 1'b0, last = 1'b0;
   logic [7:0]  mem_data;
   logic [10:0] lanes, lane_seen;
   int          err_total = 0, check_count = 0, steps = 0, carries = 0;
   always #2.5 clock = ~clock;
   always @(posedge clock) begin
      if (step === 1'b1) steps++;
      if (step_clk === 1'b1) carries++;
      if (lanes !== 11'h0) lane_seen <= lanes;
   end
   vds_core DUT (
      .clock(clock), .reset_n(reset_n), .avs_address(addr), .avs_read(rd), .avs_write(wr),
      .avs_writedata(wdata), .avs_readdata(rdata), .avs_waitrequest(waitreq),
      .ext_drive_clock(ext_clk), .probe_sync(probe), .onboard_oscillator_clock(osc),
      .ext_launch(launch), .ext_halt(halt), .ext_gate(gate), .wait_in(wait_in),
      .final_vector_flag(fin), .wait_request(wreq), .loop_stop_bit(loop_bit), .last_pass(last),
      .mem_write_data(mem_data), .lane_write(lanes), .addr_step_clock(step_clk),
      .step_pulse(step), .clock_qualify_n(qual_n)
   );
   vds_far_end far (.clock(clock), .ext_drive_clock(ext_clk), .probe_sync(probe), .onboard_oscillator_clock(osc));
   // ==========================================================================
   // Shared tasks and expectations.
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_total++;
         $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic bus(input logic w, input logic [2:0] a, input logic [7:0] d, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clock);
      addr <= a;
      wdata <= {24'h0, d};
      wr <= w;
      rd <= ~w;
      do begin
         @(posedge clock);
         n++;
      end while (waitreq !== 1'b0 && n < 100);
      if (n >= 100) check(32'h1, 32'h0);
      q = rdata;
      wr <= 1'b0;
      rd <= 1'b0;
   endtask
   task automatic wr8(input logic [2:0] a, input logic [7:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask
   task automatic rd_chk(input logic [2:0] a, input logic [31:0] exp);
      logic [31:0] q;
      bus(1'b0, a, 8'h0, q);
      check(q, exp);
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge clock);
   endtask
   task automatic strobes(input int n, input int exp);
      int s0;
      s0 = steps;
      repeat (n) wr8(ADDR_STROBE, 8'h00);
      idle(10);
      check(steps - s0, exp);
   endtask
   task automatic rearm(input logic [7:0] p);
      wr8(ADDR_POLARITY, p & 8'hFE);
      wr8(ADDR_POLARITY, p);
   endtask
   function automatic logic [31:0] st(input logic done, input logic run);
      return {28'h0, ~done, run, MODULE_TYPE};
   endfunction
   task automatic end_of_test();
      if (err_total == 0 && check_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clock);
      err_total++;
      end_of_test();
   end
   // ==========================================================================
   // Main sequence.
   initial begin
      logic [31:0] q;
      logic [7:0]  d;
      int          n, s0, c0;
      void'($urandom(96296));
      repeat (12) @(posedge clock);
      reset_n <= 1'b1;
      idle(2);
      rd_chk(ADDR_STATUS, st(1'b0, 1'b1));
      rd_chk(ADDR_OUT_CTRL, {24'h0, OC_RESET});
      rd_chk(ADDR_POLARITY, 32'h0);
      rd_chk(3'h7, 32'h0);
      rearm(8'h09);
      wr8(ADDR_OUT_CTRL, {5'h10, SEL_STEP});
      wr8(ADDR_BYTE_PORT, 8'h3C);
      wr8(ADDR_BYTE_PORT, 8'hC3);
      rd_chk(ADDR_LANE, 32'h7);
      wr8(ADDR_OUT_CTRL, {5'h00, SEL_STEP});
      bus(1'b0, ADDR_BYTE_PORT, 8'h00, q);
      wr8(ADDR_OUT_CTRL, {5'h10, SEL_STEP});
      rd_chk(ADDR_LANE, {28'h0, CHIP_START});
      c0 = carries;
      s0 = steps;
      for (int i = 0; i < 11; i++) begin
         d = 8'($urandom);
         wr8(ADDR_BYTE_PORT, d);
         idle(3);
         check(lane_seen, 32'h1 << i);
         check(mem_data, d);
         check(carries - c0, i == 10);
      end
      rd_chk(ADDR_LANE, {28'h0, CHIP_START});
      check(steps - s0, 1);
      wr8(ADDR_OUT_CTRL, 8'h85);
      for (int k = 0; k < 2; k++) begin
         gate <= 1'($urandom);
         rearm(k ? 8'h0B : 8'h09);
         n = 1 + $urandom % 4;
         strobes(n, n);
         halt <= 1'b1;
         idle(8);
         strobes(2, k ? 2 : 0);
         check(qual_n, k ? 1'b0 : 1'b1);
         halt <= 1'b0;
      end
      rearm(8'h09);
      fin <= 1'b1;
      idle(8);
      rd_chk(ADDR_STATUS, st(1'b1, 1'b1));
      strobes(2, 0);
      fin <= 1'b0;
      rearm(8'h09);
      strobes(1, 1);
      for (int k = 0; k < 2; k++) begin
         wr8(ADDR_OUT_CTRL, k ? 8'hA5 : 8'h85);
         wreq <= 1'b1;
         idle(8);
         rd_chk(ADDR_STATUS, st(1'b0, 1'b0));
         strobes(2, 0);
         wait_in <= 1'b1;
         idle(8);
         rd_chk(ADDR_STATUS, st(1'b0, k == 0));
         wait_in <= 1'b0;
         idle(8);
         rd_chk(ADDR_STATUS, st(1'b0, 1'b1));
         strobes(2, 2);
         wreq <= 1'b0;
         idle(8);
      end
      wr8(ADDR_OUT_CTRL, 8'h85);
      wreq <= 1'b1;
      idle(8);
      wr8(ADDR_POLARITY, 8'h08);
      rd_chk(ADDR_STATUS, st(1'b0, 1'b1));
      wreq <= 1'b0;
      rearm(8'h41);
      gate <= 1'b0;
      idle(8);
      strobes(2, 0);
      gate <= 1'b1;
      idle(8);
      strobes(2, 2);
      rearm(8'h1D);
      strobes(1, 0);
      launch <= 1'b1;
      idle(8);
      strobes(1, 0);
      launch <= 1'b0;
      idle(8);
      strobes(2, 2);
      loop_bit <= 1'b1;
      idle(8);
      loop_bit <= 1'b0;
      idle(8);
      loop_bit <= 1'b1;
      idle(8);
      strobes(1, 1);
      last <= 1'b1;
      loop_bit <= 1'b0;
      idle(8);
      loop_bit <= 1'b1;
      idle(8);
      rd_chk(ADDR_STATUS, st(1'b1, 1'b1));
      last <= 1'b0;
      loop_bit <= 1'b0;
      wr8(ADDR_POLARITY, 8'h08);
      wr8(ADDR_OUT_CTRL, 8'h95);
      wr8(ADDR_POLARITY, 8'h09);
      strobes(1, 0);
      wr8(ADDR_CONTROL, 8'h01);
      rd_chk(ADDR_CONTROL, 32'h1);
      strobes(1, 1);
      wr8(ADDR_CONTROL, 8'h00);
      wr8(ADDR_OUT_CTRL, 8'h85);
      for (int i = 0; i < 4; i++) begin
         rearm(i == 1 ? 8'h89 : 8'h09);
         wr8(ADDR_OUT_CTRL, {5'h10, CSEL[i]});
         n = 2 + $urandom % 4;
         s0 = steps;
         far.burst(CIDX[i], n);
         idle(10);
         check(steps - s0, n - CFALL[i]);
         wr8(ADDR_OUT_CTRL, 8'h85);
         far.park();
         idle(10);
      end
      end_of_test();
   end
endmodule // tb_vds_core
